// ==== hw/gpcs_pkg.sv ====
// gpcs_pkg: constants for the per-pin configuration subregisters of one gpio port
// assumes a byte-wide cpu register interface and eight pins per port
//
// Notes on behaviour
// [R1] software selects code 02h before alt enable access
// [R2] alt enable 0: pin is plain gpio
// [R3] alt enable 1: function sets choose owner
// [R4] two set bits pick one of four
// [R5] alt enable resets 00h, port d 01h
// [R6] software enables alt only where assigned
// [R7] software selects code 03h before open-drain access
// [R8] open-drain bit 1: never drive high
// [R9] open-drain bit 0: push-pull output drive
// [R10] open-drain applies under alternate functions too
// [R11] software selects code 04h before high-drive access
// [R12] high-drive bit: 0 standard, 1 high
// [R13] high drive also applies under alternate functions
// [R14] software selects code 05h before wake-source access
// [R15] enabled pin edge in stop raises wake
// [R16] eight bits, bit n controls pin n
// [R17] selector 00h, 09h-ffh reach nothing here
// [R18] selector value steers window reads and writes
// [R19] gpio: direction 0 drives, 1 tristates, samples
// [R20] wake-disabled pin never raises wake
// [R21] write hits selected only; read returns it
// [R22] other subregisters reset to all zeros
package gpcs_pkg;
  localparam int PIN_COUNT = 8;
  localparam int ALT_COUNT = 4;
  localparam int SET_BITS = 2;
  // selector codes
  localparam logic [7:0] SEL_DIRECTION = 8'h01;
  localparam logic [7:0] SEL_ALT_ENABLE = 8'h02;
  localparam logic [7:0] SEL_OPEN_DRAIN = 8'h03;
  localparam logic [7:0] SEL_HIGH_DRIVE = 8'h04;
  localparam logic [7:0] SEL_WAKE_SOURCE = 8'h05;
  // reset values
  localparam logic [7:0] SELECTOR_RESET = 8'h00;
  localparam logic [7:0] ALT_RESET_PORTS_ABC = 8'h00;
  localparam logic [7:0] ALT_RESET_PORT_D = 8'h01;
  localparam logic [7:0] OPEN_DRAIN_RESET = 8'h00;
  localparam logic [7:0] HIGH_DRIVE_RESET = 8'h00;
  localparam logic [7:0] WAKE_SOURCE_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  // read latency of the window and selector, in clocks
  localparam int READ_LATENCY = 1;
endpackage

// ==== hw/gpcs_port.sv ====
// gpcs_port: alt-enable, open-drain, high-drive and wake-source subregisters of one
// gpio port, plus the pin mux they steer
// assumes direction, function-set and output data come from the neighbouring port
// logic on REF_CLK; PIN_IN is asynchronous; STOP_MODE is on REF_CLK
`timescale 1ns/1ps
module gpcs_port #(
  parameter logic [7:0] ALT_RESET = gpcs_pkg::ALT_RESET_PORTS_ABC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // cpu side: selector and window strobes
  input wire logic SEL_WR,
  input wire logic SEL_RD,
  input wire logic WIN_WR,
  input wire logic WIN_RD,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  // neighbouring port configuration
  input wire logic [7:0] DIRECTION_BITS,
  input wire logic [7:0] FUNCTION_SET_LOW,
  input wire logic [7:0] FUNCTION_SET_HIGH,
  input wire logic [7:0] OUT_DATA,
  // alternate functions, four 8-bit groups, group k at bits 8k+7..8k
  input wire logic [31:0] ALT_OUT,
  input wire logic [31:0] ALT_OE,
  // pins
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic [7:0] PIN_HIGH_DRIVE,
  output logic [7:0] PIN_SAMPLED,
  // power
  input wire logic STOP_MODE,
  output logic WAKE_REQ
);

  ////////////////////////////////////////////////////////////////////////////
  // picks one of the four alternate-function bits for a pin
  function automatic logic pick_alt(input logic [31:0] grp, input int unsigned pin,
                                    input logic [1:0] fsel);
    logic [3:0] col;
    col = {grp[24 + pin], grp[16 + pin], grp[8 + pin], grp[pin]};
    pick_alt = col[fsel];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // subregister storage
  logic [7:0] selector_q;
  logic [7:0] alt_enable_q;
  logic [7:0] open_drain_q;
  logic [7:0] high_drive_q;
  logic [7:0] wake_source_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;

  wire hit_alt = (selector_q == gpcs_pkg::SEL_ALT_ENABLE);
  wire hit_od = (selector_q == gpcs_pkg::SEL_OPEN_DRAIN);
  wire hit_hd = (selector_q == gpcs_pkg::SEL_HIGH_DRIVE);
  wire hit_wake = (selector_q == gpcs_pkg::SEL_WAKE_SOURCE);
  // codes 00h, 01h and 06h-ffh leave these four alone; 01h,06h-08h belong next door
  wire [7:0] window_value = hit_alt ? alt_enable_q :   // R18
                            hit_od ? open_drain_q :
                            hit_hd ? high_drive_q :
                            hit_wake ? wake_source_q : gpcs_pkg::READ_NONE;  // R17

  // selector read takes priority if both strobes come together
  assign rd_data_d = SEL_RD ? selector_q : (WIN_RD ? window_value : rd_data_q);  // R21

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      selector_q <= gpcs_pkg::SELECTOR_RESET;
      alt_enable_q <= ALT_RESET;  // R5
      open_drain_q <= gpcs_pkg::OPEN_DRAIN_RESET;  // R22
      high_drive_q <= gpcs_pkg::HIGH_DRIVE_RESET;  // R22
      wake_source_q <= gpcs_pkg::WAKE_SOURCE_RESET;  // R22
      rd_data_q <= gpcs_pkg::READ_NONE;
    end
    else
    begin
      rd_data_q <= rd_data_d;
      if (SEL_WR)
        selector_q <= WR_DATA;
      if (WIN_WR && hit_alt)
        alt_enable_q <= WR_DATA;  // R21
      if (WIN_WR && hit_od)
        open_drain_q <= WR_DATA;  // R21
      if (WIN_WR && hit_hd)
        high_drive_q <= WR_DATA;  // R21
      if (WIN_WR && hit_wake)
        wake_source_q <= WR_DATA;  // R21
    end
  end

  assign RD_DATA = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin mux: bit n of every subregister steers pin n
  logic [7:0] drive_val;
  logic [7:0] drive_en;
  logic [7:0] pin_out_d;
  logic [7:0] pin_oe_d;

  for (genvar n = 0; n < gpcs_pkg::PIN_COUNT; n++)
  begin : g_pin
    wire [1:0] fsel = {FUNCTION_SET_HIGH[n], FUNCTION_SET_LOW[n]};  // R4
    // gpio: direction 0 drives output data, 1 tristates
    assign drive_val[n] = alt_enable_q[n] ? pick_alt(ALT_OUT, n, fsel) : OUT_DATA[n];  // R2 R3 R16
    assign drive_en[n] = alt_enable_q[n] ? pick_alt(ALT_OE, n, fsel) : ~DIRECTION_BITS[n];  // R19
    // open drain only ever pulls low; the driver is released for a one
    assign pin_out_d[n] = drive_val[n] & ~open_drain_q[n];  // R8 R9 R10
    assign pin_oe_d[n] = drive_en[n] & (~open_drain_q[n] | ~drive_val[n]);  // R8 R10
  end

  // registered pads avoid glitches while the mux inputs settle
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      PIN_OUT <= 8'h00;
      PIN_OE <= 8'h00;
      PIN_HIGH_DRIVE <= 8'h00;
    end
    else
    begin
      PIN_OUT <= pin_out_d;
      PIN_OE <= pin_oe_d;
      PIN_HIGH_DRIVE <= high_drive_q;  // R12 R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser and wake detection
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;
  logic [7:0] pin_prev_q;
  logic wake_q;

  // any edge on an enabled pin; the extra stage costs one clock of wake latency
  wire [7:0] pin_edge = pin_sync_q ^ pin_prev_q;
  wire wake_d = STOP_MODE & |(pin_edge & wake_source_q);  // R15 R20

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
      pin_prev_q <= 8'h00;
      wake_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= PIN_IN;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      wake_q <= wake_d;
    end
  end

  assign PIN_SAMPLED = pin_sync_q;  // R19
  assign WAKE_REQ = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // check helper: marks the first cycle after reset, so the reset contents
  // can be looked at once the default disable has let go
  logic in_reset_q;

  always_ff @(posedge REF_CLK)
  begin
    in_reset_q <= !RST_B;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  a_alt_write_lands: assert property (  // R21
    (SEL_WR && WR_DATA == gpcs_pkg::SEL_ALT_ENABLE) ##1 (WIN_WR && !SEL_WR)
    |=> alt_enable_q == $past(WR_DATA))
    else $error("alt enable write through window lost");

  a_window_isolated: assert property (  // R17
    (WIN_WR && !hit_alt && !hit_od && !hit_hd && !hit_wake)
    |=> $stable(alt_enable_q) && $stable(open_drain_q) && $stable(high_drive_q)
        && $stable(wake_source_q))
    else $error("unmapped selector changed a subregister");

  a_window_readback: assert property (  // R18
    (WIN_RD && !SEL_RD && hit_od) |=> RD_DATA == $past(open_drain_q))
    else $error("window read did not return the selected subregister");

  a_opendrain_nohigh: assert property (  // R8
    (open_drain_q == 8'hff && !WIN_WR) |=> (PIN_OE & PIN_OUT) == 8'h00)
    else $error("open-drain pin driven high");

  a_gpio_direction: assert property (  // R19
    (alt_enable_q[0] == 1'b0 && open_drain_q[0] == 1'b0)
    |=> PIN_OE[0] == ~$past(DIRECTION_BITS[0]) && PIN_OUT[0] == $past(OUT_DATA[0]))
    else $error("gpio pin 0 direction or data wrong");

  a_alt_owns_pin: assert property (  // R3
    (alt_enable_q[2] && open_drain_q[2] == 1'b0
     && FUNCTION_SET_HIGH[2] && !FUNCTION_SET_LOW[2])
    |=> PIN_OUT[2] == $past(ALT_OUT[18]) && PIN_OE[2] == $past(ALT_OE[18]))
    else $error("alternate function 2 not routed to pin 2");

  a_high_drive_follow: assert property (  // R12
    (WIN_WR && hit_hd) |=> ##1 PIN_HIGH_DRIVE == $past(WR_DATA, 2))
    else $error("high drive not applied to pins");

  a_wake_edge: assert property (  // R15
    (STOP_MODE && wake_source_q[2] && pin_sync_q[2] != pin_prev_q[2]) |=> WAKE_REQ)
    else $error("enabled pin edge in stop gave no wake");

  a_wake_quiet: assert property (  // R20
    (!STOP_MODE || wake_source_q == 8'h00) |=> !WAKE_REQ)
    else $error("wake raised without stop or enabled source");

  // alternate functions 0 and 3 on their own pins, so with pin 2 set codes 0, 2 and 3 are seen
  a_alt_pin_zero: assert property (  // R4
    (alt_enable_q[0] && open_drain_q[0] == 1'b0
     && !FUNCTION_SET_HIGH[0] && !FUNCTION_SET_LOW[0])
    |=> PIN_OUT[0] == $past(ALT_OUT[0]) && PIN_OE[0] == $past(ALT_OE[0]))
    else $error("alternate function 0 not routed to pin 0");

  a_alt_pin_three: assert property (  // R4
    (alt_enable_q[3] && open_drain_q[3] == 1'b0
     && FUNCTION_SET_HIGH[3] && FUNCTION_SET_LOW[3])
    |=> PIN_OUT[3] == $past(ALT_OUT[27]) && PIN_OE[3] == $past(ALT_OE[27]))
    else $error("alternate function 3 not routed to pin 3");

  // whole-port versions of the pin checks; one line each instead of one per pin
  a_opendrain_each: assert property (  // R8 R10
    1'b1 |=> (PIN_OE & PIN_OUT & $past(open_drain_q)) == 8'h00)
    else $error("open-drain bit set but pin driven high");

  a_pushpull_data: assert property (  // R9
    1'b1 |=> ((PIN_OUT ^ $past(drive_val)) & ~$past(open_drain_q)) == 8'h00)
    else $error("push-pull pin does not carry its drive value");

  a_gpio_all_pins: assert property (  // R2 R19
    1'b1 |=> ((PIN_OE ^ ~$past(DIRECTION_BITS)) & ~$past(alt_enable_q)
              & ~$past(open_drain_q)) == 8'h00)
    else $error("gpio pin enable does not follow direction");

  a_high_drive_copy: assert property (  // R12 R13
    1'b1 |=> PIN_HIGH_DRIVE == $past(high_drive_q))
    else $error("pin drive strength differs from its subregister");

  // two synchroniser stages between the pad and the sampled value
  a_sampled_path: assert property (  // R19
    1'b1 |=> ##1 PIN_SAMPLED == $past(PIN_IN, 2))
    else $error("sampled pin value not two clocks behind the pad");

  a_wake_any_pin: assert property (  // R15
    (STOP_MODE && |((pin_sync_q ^ pin_prev_q) & wake_source_q)) |=> WAKE_REQ)
    else $error("enabled pin edge in stop gave no wake on some pin");

  ////////////////////////////////////////////////////////////////////////////
  // register bus checks
  a_selector_read: assert property (  // R18
    SEL_RD |=> RD_DATA == $past(selector_q))
    else $error("selector read returned a wrong value");

  a_read_holds: assert property (  // R21
    (!SEL_RD && !WIN_RD) |=> $stable(RD_DATA))
    else $error("read data changed without a read");

  a_unmapped_read: assert property (  // R17
    (WIN_RD && !SEL_RD && !hit_alt && !hit_od && !hit_hd && !hit_wake)
    |=> RD_DATA == gpcs_pkg::READ_NONE)
    else $error("unmapped selector read returned data");

  a_write_only_selected: assert property (  // R21
    (WIN_WR && hit_wake)
    |=> wake_source_q == $past(WR_DATA) && $stable(alt_enable_q)
        && $stable(open_drain_q) && $stable(high_drive_q))
    else $error("window write reached a subregister not selected");

  // the helper flop is unknown before the first edge, which keeps this quiet
  a_reset_state: assert property (  // R5 R22
    (in_reset_q && RST_B)
    |-> alt_enable_q == ALT_RESET
        && open_drain_q == gpcs_pkg::OPEN_DRAIN_RESET
        && high_drive_q == gpcs_pkg::HIGH_DRIVE_RESET
        && wake_source_q == gpcs_pkg::WAKE_SOURCE_RESET
        && selector_q == gpcs_pkg::SELECTOR_RESET)
    else $error("subregisters not at reset values after reset");

  c_alt_enabled: cover property (WIN_WR && hit_alt && WR_DATA != 8'h00);
  c_wake_event: cover property (STOP_MODE ##1 WAKE_REQ);
  c_opendrain_low: cover property (open_drain_q[3] && PIN_OE[3]);
  c_selector_read: cover property (SEL_WR ##1 SEL_RD ##1 RD_DATA != 8'h00);
  c_alt_pin_two: cover property (alt_enable_q[2] && FUNCTION_SET_HIGH[2] && !FUNCTION_SET_LOW[2]);

endmodule

// ==== bench/gpcs_pad_model.sv ====
// gpcs_pad_model: pads and alternate-function sources around one port
// assumes the port drives the pads from PIN_OUT and PIN_OE
`timescale 1ns/1ps
module gpcs_pad_model (
  // pad side
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE,
  input wire logic [7:0] EXT_LEVEL,
  output logic [7:0] PIN_IN,
  // alternate functions
  output logic [31:0] ALT_OUT,
  output logic [31:0] ALT_OE
);
  // every pin has a source in all four groups, so any enable is legal
  assign ALT_OUT = 32'h3c96a50f;
  assign ALT_OE = 32'hf0ff5ac3;
  // the port wins where it drives, the outside device elsewhere
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & EXT_LEVEL);
endmodule

// ==== bench/gpcs_port_tb.sv ====
// gpcs_port_tb: register and pin checks of one port set up as port d
// assumes gpcs_port with strobe access and the pad model beside it
`timescale 1ns/1ps
module gpcs_port_tb;
  logic ref_clk, rst_b, sel_wr, sel_rd, win_wr, win_rd, stop_mode, wake_req;
  logic [7:0] wr_data, rd_data, dir_bits, fs_low, fs_high, out_data, ext_level;
  logic [7:0] pin_in, pin_out, pin_oe, pin_hd, pin_smp, e_out, e_oe;
  logic [31:0] alt_out, alt_oe;
  logic [7:0] bad [5] = '{8'h00, 8'h01, 8'h06, 8'h09, 8'hff};
  int n_mismatch, check_count, k;
  gpcs_port #(.ALT_RESET(gpcs_pkg::ALT_RESET_PORT_D)) gpcs_port_inst (
    .REF_CLK(ref_clk), .RST_B(rst_b), .SEL_WR(sel_wr), .SEL_RD(sel_rd),
    .WIN_WR(win_wr), .WIN_RD(win_rd), .WR_DATA(wr_data), .RD_DATA(rd_data),
    .DIRECTION_BITS(dir_bits), .FUNCTION_SET_LOW(fs_low), .FUNCTION_SET_HIGH(fs_high),
    .OUT_DATA(out_data), .ALT_OUT(alt_out), .ALT_OE(alt_oe), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_HIGH_DRIVE(pin_hd),
    .PIN_SAMPLED(pin_smp), .STOP_MODE(stop_mode), .WAKE_REQ(wake_req));
  gpcs_pad_model gpcs_pad_model_inst (
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .EXT_LEVEL(ext_level),
    .PIN_IN(pin_in), .ALT_OUT(alt_out), .ALT_OE(alt_oe));
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    check_count++;
    if (a !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  // selector first, window on the next edge
  task automatic wr(input logic [7:0] s, input logic [7:0] v);
    sel_wr = 1'h1;
    wr_data = s;
    tick(1);
    sel_wr = 1'h0;
    win_wr = 1'h1;
    wr_data = v;
    tick(1);
    win_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] s, input logic [7:0] e);
    sel_wr = 1'h1;
    wr_data = s;
    tick(1);
    sel_wr = 1'h0;
    win_rd = 1'h1;
    tick(1);
    win_rd = 1'h0;
    chk(rd_data, e);
  endtask
  // wake is a one-cycle pulse, so watch every edge of the window
  task automatic wake_wait(input logic e);
    logic seen;
    seen = 1'h0;
    repeat (8)
    begin
      tick(1);
      seen = seen | wake_req;
    end
    chk({7'h0, seen}, {7'h0, e});
    if (e && !seen)
      end_sim();
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    {rst_b, sel_wr, sel_rd, win_wr, win_rd, stop_mode} = 6'h0;
    {wr_data, fs_low, fs_high, out_data, ext_level} = 40'h0;
    dir_bits = 8'hff;
    tick(10);
    rst_b = 1'h1;
    tick(1);
    chk(pin_oe, 8'h01);
    rd(8'h02, 8'h01);
    for (k = 3; k < 6; k++)
      rd(8'(k), 8'h00);
    $display("test reset done");
    for (k = 2; k < 6; k++)
      wr(8'(k), 8'h30 + 8'(k));
    for (k = 0; k < 5; k++)
      wr(bad[k], 8'hee);
    for (k = 2; k < 6; k++)
      rd(8'(k), 8'h30 + 8'(k));
    for (k = 0; k < 5; k++)
      rd(bad[k], 8'h00);
    $display("test window done");
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    dir_bits = 8'hf0;
    out_data = 8'h5a;
    ext_level = 8'h50;
    tick(4);
    chk(pin_out & 8'h0f, 8'h0a);
    chk(pin_oe, 8'h0f);
    chk(pin_smp, 8'h5a);
    fs_low = 8'haa;
    fs_high = 8'hcc;
    wr(8'h02, 8'hff);
    tick(2);
    for (k = 0; k < 8; k++)
    begin
      e_out[k] = alt_out[8 * int'({fs_high[k], fs_low[k]}) + k];
      e_oe[k] = alt_oe[8 * int'({fs_high[k], fs_low[k]}) + k];
    end
    chk(pin_out & e_oe, e_out & e_oe);
    chk(pin_oe, e_oe);
    wr(8'h03, 8'hff);
    wr(8'h04, 8'ha5);
    tick(2);
    chk(pin_out, 8'h00);
    chk(pin_oe, e_oe & ~e_out);
    chk(pin_hd, 8'ha5);
    $display("test pins done");
    dir_bits = 8'hff;
    ext_level = 8'h00;
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h05, 8'h04);
    tick(8);
    stop_mode = 1'h1;
    ext_level = 8'h08;
    wake_wait(1'h0);
    ext_level = 8'h0c;
    wake_wait(1'h1);
    ext_level = 8'h08;
    wake_wait(1'h1);
    stop_mode = 1'h0;
    ext_level = 8'h0c;
    wake_wait(1'h0);
    $display("test wake done");
    end_sim();
  end
endmodule
